/* File: core/cmp_ctrl_pkg.sv */
// Package of constants and types for the dual comparator control block
package cmp_ctrl_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h01;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h02;
  localparam int         BIT_C2_OUT    = 7;
  localparam int         BIT_C1_OUT    = 6;
  localparam int         BIT_C2_INV    = 5;
  localparam int         BIT_C1_INV    = 4;
  localparam int         BIT_SWITCH    = 3;
  localparam logic [2:0] MODE_MUX4     = 3'h6;
  localparam logic [2:0] MODE_OFF      = 3'h7;
  localparam logic [2:0] MODE_RESET    = 3'h7;
  localparam int         SYNC_STAGES   = 3;
  // Input selector codes for the analog switch matrix
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_AN0  = 3'h1,
    SEL_AN1  = 3'h2,
    SEL_AN2  = 3'h3,
    SEL_AN3  = 3'h4,
    SEL_VREF = 3'h5
  } in_sel_e;
  typedef struct packed {
    in_sel_e c1_pos;
    in_sel_e c1_neg;
    in_sel_e c2_pos;
    in_sel_e c2_neg;
    logic    c1_on;
    logic    c2_on;
  } route_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;
endpackage

/* File: core/cmp_route.sv */
// Mode decoder for comparator input routing
`timescale 1ns/10ps
`default_nettype none
module cmp_route (
  input  wire logic [2:0]          mode,
  input  wire logic                in_switch,
  output cmp_ctrl_pkg::route_s     route
);
  always_comb begin
    route = '{cmp_ctrl_pkg::SEL_AN0, cmp_ctrl_pkg::SEL_AN3,
              cmp_ctrl_pkg::SEL_AN1, cmp_ctrl_pkg::SEL_AN2, 1'b1, 1'b1};
    if (mode == cmp_ctrl_pkg::MODE_OFF) begin
      route = '{cmp_ctrl_pkg::SEL_NONE, cmp_ctrl_pkg::SEL_NONE,
                cmp_ctrl_pkg::SEL_NONE, cmp_ctrl_pkg::SEL_NONE,
                1'b0, 1'b0};
    end else if (mode == cmp_ctrl_pkg::MODE_MUX4) begin
      route.c1_pos = cmp_ctrl_pkg::SEL_VREF;
      route.c2_pos = cmp_ctrl_pkg::SEL_VREF;
      if (in_switch) begin
        route.c1_neg = cmp_ctrl_pkg::SEL_AN3;
        route.c2_neg = cmp_ctrl_pkg::SEL_AN2;
      end else begin
        route.c1_neg = cmp_ctrl_pkg::SEL_AN0;
        route.c2_neg = cmp_ctrl_pkg::SEL_AN1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/cmp_sync.sv */
// Three-stage synchroniser with agreement filter for one comparator output
`timescale 1ns/10ps
`default_nettype none
module cmp_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic raw,
  output logic      clean
);
  typedef struct packed {
    logic [cmp_ctrl_pkg::SYNC_STAGES-1:0] sh;
    logic                                 q;
  } sync_s;
  sync_s st;
  sync_s next_st;
  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[cmp_ctrl_pkg::SYNC_STAGES-2:0], raw};
    // First stage is read only by the second; stages two and three must agree
    if (st.sh[1] == st.sh[2]) begin
      next_st.q = st.sh[2];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign clean = st.q;
endmodule
`default_nettype wire

/* File: core/dual_comparator_control.sv */
// Control register, result capture and change interrupt for two comparators
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_control (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  input  wire logic                 cmp1_raw,
  input  wire logic                 cmp2_raw,
  output logic                      cmp1_pin,
  output logic                      cmp2_pin,
  output cmp_ctrl_pkg::route_s      route,
  output logic                      cmp_change_flag,
  output logic                      irq
);
  typedef struct packed {
    logic [1:0]           inv;
    logic                 input_switch_sel;
    logic [2:0]           cmp_mode_field;
    logic [1:0]           latched;
    logic                 flag;
    logic                 mask;
    logic [7:0]           rdata;
    logic                 pin1;
    logic                 pin2;
    logic                 irq;
    cmp_ctrl_pkg::route_s route;
  } state_s;

  state_s            st;
  state_s            next_st;
  logic              s1;
  logic              s2;
  logic [1:0]        res;
  logic [7:0]        ctrl_view;
  logic              mismatch;
  cmp_ctrl_pkg::route_s next_route;
  cmp_ctrl_pkg::bus_req_s req;

  assign req = '{addr, wdata, wr, rd};

  cmp_sync u_sync1 (
    .clk   (clk),
    .rstn  (rstn),
    .raw   (cmp1_raw),
    .clean (s1)
  );
  cmp_sync u_sync2 (
    .clk   (clk),
    .rstn  (rstn),
    .raw   (cmp2_raw),
    .clean (s2)
  );
  cmp_route u_route (
    .mode      (next_st.cmp_mode_field),
    .in_switch (next_st.input_switch_sel),
    .route     (next_route)
  );

  // Results after optional inversion; index 1 is comparator 2
  assign res[1] = s2 ^ st.inv[1];
  assign res[0] = s1 ^ st.inv[0];
  // Results are not forced low in off mode, so a mode change can raise the flag
  assign ctrl_view = {res, st.inv, st.input_switch_sel, st.cmp_mode_field};
  assign mismatch = (res != st.latched);

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    if (req.wr && req.addr == cmp_ctrl_pkg::ADDR_CONTROL) begin
      // Result bits are not writable
      next_st.inv[1] = req.wdata[cmp_ctrl_pkg::BIT_C2_INV];
      next_st.inv[0] = req.wdata[cmp_ctrl_pkg::BIT_C1_INV];
      next_st.input_switch_sel = req.wdata[cmp_ctrl_pkg::BIT_SWITCH];
      next_st.cmp_mode_field = req.wdata[2:0];
    end
    if (req.rd) begin
      case (req.addr)
        cmp_ctrl_pkg::ADDR_CONTROL:  next_st.rdata = ctrl_view;
        cmp_ctrl_pkg::ADDR_IRQ_STAT: next_st.rdata = {7'h00, st.flag};
        cmp_ctrl_pkg::ADDR_IRQ_MASK: next_st.rdata = {7'h00, st.mask};
        default:                     next_st.rdata = 8'h00;
      endcase
    end
    // Any access to the control register ends the mismatch
    if ((req.rd || req.wr) && req.addr == cmp_ctrl_pkg::ADDR_CONTROL) begin
      next_st.latched = res;
    end
    if (req.wr && req.addr == cmp_ctrl_pkg::ADDR_IRQ_MASK) begin
      next_st.mask = req.wdata[0];
    end
    if (req.wr && req.addr == cmp_ctrl_pkg::ADDR_IRQ_STAT && req.wdata[0]) begin
      next_st.flag = 1'b0;
    end
    // Set beats clear, so a clear only sticks once the mismatch is gone
    if (mismatch) begin
      next_st.flag = 1'b1;
    end
    next_st.pin1 = res[0];
    next_st.pin2 = res[1];
    next_st.irq = next_st.flag & next_st.mask;
    next_st.route = next_route;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      st.cmp_mode_field <= cmp_ctrl_pkg::MODE_RESET;
      st.route <= '{cmp_ctrl_pkg::SEL_NONE, cmp_ctrl_pkg::SEL_NONE,
                    cmp_ctrl_pkg::SEL_NONE, cmp_ctrl_pkg::SEL_NONE,
                    1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign cmp1_pin = st.pin1;
  assign cmp2_pin = st.pin2;
  assign route = st.route;
  assign cmp_change_flag = st.flag;
  assign irq = st.irq;
endmodule
`default_nettype wire

/* File: verification/cmp_analog_model.sv */
// Analog inputs and reference seen as comparator outcomes
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model (
  input  wire cmp_ctrl_pkg::route_s route,
  input  wire logic                 lvl1,
  input  wire logic                 lvl2,
  output logic                      cmp1_raw,
  output logic                      cmp2_raw
);
  // A comparator that is off idles low, so entering or leaving off mode shows as an edge while its level is high
  assign cmp1_raw = route.c1_on & lvl1;
  assign cmp2_raw = route.c2_on & lvl2;
endmodule
`default_nettype wire

/* File: verification/dcc_assertions.sv */
// Checker for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module dcc_check (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic [7:0]           addr,
  input wire logic [7:0]           wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire logic [7:0]           rdata,
  input wire logic                 cmp1_raw,
  input wire logic                 cmp1_pin,
  input wire logic                 cmp2_pin,
  input wire cmp_ctrl_pkg::route_s route,
  input wire logic                 cmp_change_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic c0;
  assign c0 = wr && addr == 8'h00;
  sequence rd_ctl;
    rd && addr == 8'h00 ##1 $stable({cmp2_pin, cmp1_pin});
  endsequence
  a_ref_inputs: assert property (
    c0 && wdata[2:0] == 3'h6 |=> route.c1_pos == cmp_ctrl_pkg::SEL_VREF
    && route.c2_pos == cmp_ctrl_pkg::SEL_VREF) else $error("ref route");
  a_switch_high: assert property (
    c0 && wdata[3:0] == 4'he |=> route.c1_neg == cmp_ctrl_pkg::SEL_AN3
    && route.c2_neg == cmp_ctrl_pkg::SEL_AN2) else $error("switch high");
  a_switch_low: assert property (
    c0 && wdata[3:0] == 4'h6 |=> route.c1_neg == cmp_ctrl_pkg::SEL_AN0
    && route.c2_neg == cmp_ctrl_pkg::SEL_AN1) else $error("switch low");
  a_mode_off: assert property (
    c0 && wdata[2:0] == 3'h7 |=> !route.c1_on && !route.c2_on)
    else $error("mode off");
  a_read_results: assert property (
    rd_ctl |-> rdata[7:6] == {cmp2_pin, cmp1_pin}) else $error("results");
  a_flag_raise: assert property (
    $changed(cmp1_raw) |-> ##[1:8] cmp_change_flag) else $error("no flag");
  a_flag_sticky: assert property (
    cmp_change_flag && !(wr && addr == 8'h01) |=> cmp_change_flag)
    else $error("flag lost");
  a_sync_delay: assert property (
    $changed(cmp1_raw) && !wr && !$past(wr) |=> $stable(cmp1_pin))
    else $error("no sync");
endmodule
bind dual_comparator_control dcc_check chk (.clk, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .cmp1_raw, .cmp1_pin, .cmp2_pin, .route,
  .cmp_change_flag);
`default_nettype wire

/* File: verification/test_dual_comparator_control.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module test_dual_comparator_control;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, lvl1 = 0, lvl2 = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic cmp1_raw, cmp2_raw, cmp1_pin, cmp2_pin, cmp_change_flag, irq;
  cmp_ctrl_pkg::route_s route;
  int fail_count = 0, tests_run = 0, cycles = 0;
  always #50 clk = ~clk;
  dual_comparator_control uut (.clk, .rstn, .addr, .wdata, .wr, .rd,
    .rdata, .cmp1_raw, .cmp2_raw, .cmp1_pin, .cmp2_pin, .route,
    .cmp_change_flag, .irq);
  cmp_analog_model far (.route, .lvl1, .lvl2, .cmp1_raw, .cmp2_raw);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic put(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    get(8'h00, 8'h07);
    get(8'h01, 8'h00);
    put(8'h00, 8'hc6);
    get(8'h00, 8'h06);
    for (int i = 0; i < 16; i++) begin
      lvl1 <= i[2];
      lvl2 <= i[3];
      put(8'h00, {2'b00, i[1:0], 4'he});
      hold(8);
      get(8'h00, {i[3] ^ i[1], i[2] ^ i[0], i[1:0], 4'he});
      chk("pins", {6'h00, i[3] ^ i[1], i[2] ^ i[0]},
        {6'h00, cmp2_pin, cmp1_pin});
    end
    put(8'h02, 8'h01);
    put(8'h01, 8'h01);
    hold(3);
    chk("irq", 8'h00, {7'h00, irq});
    lvl1 <= 1'b0;
    hold(8);
    chk("irq", 8'h01, {7'h00, irq});
    chk("flag", 8'h01, {7'h00, cmp_change_flag});
    put(8'h01, 8'h01);
    get(8'h01, 8'h01);
    get(8'h00, 8'h7e);
    put(8'h01, 8'h01);
    get(8'h01, 8'h00);
    chk("flag", 8'h00, {7'h00, cmp_change_flag});
    put(8'h02, 8'h00);
    lvl1 <= 1'b1;
    hold(8);
    get(8'h01, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    put(8'h10, 8'hff);
    get(8'h10, 8'h00);
    get(8'h00, 8'h3e);
    put(8'h00, 8'h07);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    get(8'h00, 8'h07);
    get(8'h01, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
